//--- src/bscp_pkg.sv
// Holds the shared constants, state encodings and state layout of the boot-select and code-protection block.
// Assumes one 40 MHz clock, hclk, and a single AHB-Lite slave port reaching the registers.
package bscp_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] BOOT_CTRL_IDX = 8'hbf;
  localparam logic [11:0] BOOT_CTRL_ADDR = {2'h0, BOOT_CTRL_IDX, 2'h0};
  localparam logic [11:0] UNLOCK_ADDR = 12'h300;
  localparam logic [11:0] SECURITY_ADDR = 12'h304;
  localparam logic [11:0] ERASE_ADDR = 12'h308;
  localparam logic [11:0] STATUS_ADDR = 12'h30c;
  localparam logic [11:0] ID_ADDR = 12'h310;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int CTRL_REBOOT_BIT = 7;
  localparam int CTRL_AUX_BIT = 4;
  localparam int CTRL_SEL_BIT = 1;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h87;
  localparam logic [7:0] UNLOCK_KEY2 = 8'h59;
  localparam logic [7:0] ERASE_KEY = 8'ha5;
  localparam int SEC_LOCK_BIT = 0;
  localparam int SEC_TBL_BIT = 1;
  localparam int SEC_ENC_BIT = 2;
  localparam int SEC_GAIN_BIT = 7;
  localparam logic [7:0] SEC_RESET = 8'hff;
  localparam logic [15:0] SEC_BYTE_LOC = 16'hffff;

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESET_CYCLES = 8'h10;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    UL_CLOSED = 3'b001,
    UL_HALF = 3'b010,
    UL_OPEN = 3'b100
  } bscp_unlock_e;

  typedef struct packed {
    logic ph_valid;
    logic ph_write;
    logic [11:0] ph_addr;
    bscp_unlock_e unlock;
    logic aux_en;
    logic loc_sel;
    logic prog_en;
    logic loader_boot;
    logic isp_mode;
    logic [7:0] sec;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] cap_cnt;
    logic [7:0] rst_cnt;
    logic [7:0] p0_out;
    logic [7:0] sec_data;
  } bscp_state_s;

endpackage : bscp_pkg

//--- src/bscp_top.sv
// Holds the boot-select, reprogramming-enable, software reboot and code-protection logic with its AHB-Lite slave.
// Assumes the core drives the idle, wake and table-read signals on hclk; strap pins are asynchronous.
// Behaviour
// - Reboot bit written with select and enable both set forces a full reset.
// - Control bit 7 reads 1 while the forced loader-bank boot is running.
// - Control bit 4 enables the auxiliary RAM, clear disables it.
// - Select 0 targets the loader bank; select 1 targets the application bank.
// - With enable set, idle then interrupt wake enters reprogramming; operations run in idle.
// - With enable clear, program memory is read-only and reprogramming is blocked.
// - After power-on the core starts from the application bank by default.
// - Straps low at reset (P2.6 and P2.7, or P4.3) force loader-bank boot.
// - Programmed security bits return to 1 only through a full erase or an hresetn reset.
// - Security and identity values are hidden while in programming mode.
// - The security byte sits at address ffff of the loader bank.
// - Lock bit 0 blocks access to program memory and setting registers.
// - Inhibit 0: table reads from external code reach external memory only.
// - Table reads from internal code may always reach internal and external memory.
// - Inhibit 1: table reads are unrestricted.
// - Encryption enabled encodes port 0 data; only full erase or hresetn clears it.
// - Security bit 7 at 0 halves the oscillator amplifier gain.
`timescale 1ns/1ps
module bscp_top #(
  parameter logic [7:0] ENC_KEY = 8'h5a,
  parameter logic [7:0] COMPANY_ID = 8'h11, // Arbitrary value.
  parameter logic [7:0] DEVICE_ID = 8'h22 // Arbitrary value.
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic p2_6_pin,
  input wire logic p2_7_pin,
  input wire logic p4_3_pin,
  input wire logic core_idle,
  input wire logic wake_irq,
  input wire logic tbl_from_internal,
  input wire logic tbl_to_internal,
  input wire logic loader_rd,
  input wire logic [15:0] loader_addr,
  input wire logic [7:0] p0_data_in,
  output logic sys_reset_n,
  output logic boot_from_loader,
  output logic aux_ram_enable,
  output logic target_is_loader,
  output logic isp_mode,
  output logic rom_op_allow,
  output logic tbl_internal_grant,
  output logic ext_access_allow,
  output logic sec_hit,
  output logic [7:0] sec_data,
  output logic [7:0] p0_data_out,
  output logic osc_half_gain
);

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  bscp_pkg::bscp_state_s s;
  bscp_pkg::bscp_state_s next_s;
  logic dwr;
  logic drd;
  logic ctrl_wr;
  logic reboot_req;
  logic sec_open;
  logic [7:0] ctrl_rd;
  logic [7:0] status_rd;

  assign dwr = s.ph_valid & s.ph_write;
  assign drd = s.ph_valid & ~s.ph_write;
  assign ctrl_wr = dwr && (s.ph_addr == bscp_pkg::BOOT_CTRL_ADDR) && (s.unlock == bscp_pkg::UL_OPEN)
    && (s.rst_cnt == 8'h00);
  assign reboot_req = ctrl_wr & hwdata[bscp_pkg::CTRL_REBOOT_BIT] & hwdata[bscp_pkg::CTRL_SEL_BIT]
    & hwdata[bscp_pkg::CTRL_EN_BIT];
  assign sec_open = ~s.isp_mode & s.sec[bscp_pkg::SEC_LOCK_BIT];
  assign ctrl_rd = {s.loader_boot, 2'h0, s.aux_en, 2'h0, s.loc_sel, s.prog_en};
  assign status_rd = {3'h0, ~s.sec[bscp_pkg::SEC_ENC_BIT], ~s.loc_sel, s.isp_mode, s.loader_boot, sys_reset_n};

  always_comb begin
    next_s = s;
    next_s.s1 = {p4_3_pin, p2_7_pin, p2_6_pin};
    next_s.s2 = s.s1;
    next_s.ph_valid = hsel & htrans[1] & hready;
    next_s.ph_write = hwrite;
    next_s.ph_addr = haddr[11:0];
    if (dwr && (s.ph_addr == bscp_pkg::UNLOCK_ADDR)) begin
      if (hwdata[7:0] == bscp_pkg::UNLOCK_KEY1) begin
        next_s.unlock = bscp_pkg::UL_HALF;
      end else if ((hwdata[7:0] == bscp_pkg::UNLOCK_KEY2) && (s.unlock == bscp_pkg::UL_HALF)) begin
        next_s.unlock = bscp_pkg::UL_OPEN;
      end else begin
        next_s.unlock = bscp_pkg::UL_CLOSED;
      end
    end
    if (ctrl_wr) begin
      next_s.aux_en = hwdata[bscp_pkg::CTRL_AUX_BIT];
      next_s.loc_sel = hwdata[bscp_pkg::CTRL_SEL_BIT];
      next_s.prog_en = hwdata[bscp_pkg::CTRL_EN_BIT];
    end
    if (reboot_req) begin
      next_s.rst_cnt = bscp_pkg::RESET_CYCLES;
    end
    if (core_idle && wake_irq) begin
      next_s.isp_mode = s.prog_en;
    end
    if (dwr && (s.ph_addr == bscp_pkg::SECURITY_ADDR) && sec_open) begin
      next_s.sec = s.sec & hwdata[7:0];
    end
    if (dwr && (s.ph_addr == bscp_pkg::ERASE_ADDR) && (hwdata[7:0] == bscp_pkg::ERASE_KEY) && ~s.isp_mode) begin
      next_s.sec = bscp_pkg::SEC_RESET;
    end
    if (~s.sec[bscp_pkg::SEC_ENC_BIT]) begin
      next_s.p0_out = p0_data_in ^ ENC_KEY;
    end else begin
      next_s.p0_out = p0_data_in;
    end
    next_s.sec_data = 8'h00;
    if (loader_rd && (loader_addr == bscp_pkg::SEC_BYTE_LOC) && sec_open) begin
      next_s.sec_data = s.sec;
    end
    if (s.rst_cnt != 8'h00) begin
      next_s.rst_cnt = s.rst_cnt - 8'h01;
      next_s.unlock = bscp_pkg::UL_CLOSED;
      next_s.aux_en = 1'b0;
      next_s.loc_sel = 1'b0;
      next_s.prog_en = 1'b0;
      next_s.isp_mode = 1'b0;
      next_s.loader_boot = 1'b0;
      next_s.cap_cnt = bscp_pkg::STRAP_SETTLE;
    end else if (s.cap_cnt != 2'h0) begin
      next_s.cap_cnt = s.cap_cnt - 2'h1;
      if (s.cap_cnt == 2'h1) begin
        next_s.loader_boot = (~s.s2[1] & ~s.s2[0]) | ~s.s2[2];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '{ph_valid: 1'b0, ph_write: 1'b0, ph_addr: 12'h000, unlock: bscp_pkg::UL_CLOSED, aux_en: 1'b0,
             loc_sel: 1'b0, prog_en: 1'b0, loader_boot: 1'b0, isp_mode: 1'b0, sec: bscp_pkg::SEC_RESET,
             s1: 3'h7, s2: 3'h7, cap_cnt: bscp_pkg::STRAP_SETTLE, rst_cnt: 8'h00, p0_out: 8'h00,
             sec_data: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // Bus read data and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    hrdata = 32'h0000_0000;
    if (drd && (s.ph_addr == bscp_pkg::BOOT_CTRL_ADDR)) begin
      hrdata = {24'h000000, ctrl_rd};
    end else if (drd && (s.ph_addr == bscp_pkg::SECURITY_ADDR) && sec_open) begin
      hrdata = {24'h000000, s.sec};
    end else if (drd && (s.ph_addr == bscp_pkg::STATUS_ADDR)) begin
      hrdata = {24'h000000, status_rd};
    end else if (drd && (s.ph_addr == bscp_pkg::ID_ADDR) && sec_open) begin
      hrdata = {16'h0000, DEVICE_ID, COMPANY_ID};
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign sys_reset_n = (s.rst_cnt == 8'h00) && (s.cap_cnt == 2'h0);
  assign boot_from_loader = s.loader_boot;
  assign aux_ram_enable = s.aux_en;
  assign target_is_loader = ~s.loc_sel;
  assign isp_mode = s.isp_mode;
  assign rom_op_allow = s.isp_mode & s.prog_en & core_idle;
  assign tbl_internal_grant = tbl_to_internal & (tbl_from_internal | s.sec[bscp_pkg::SEC_TBL_BIT]);
  assign ext_access_allow = s.sec[bscp_pkg::SEC_LOCK_BIT];
  assign sec_hit = loader_rd & (loader_addr == bscp_pkg::SEC_BYTE_LOC);
  assign sec_data = s.sec_data;
  assign p0_data_out = s.p0_out;
  assign osc_half_gain = ~s.sec[bscp_pkg::SEC_GAIN_BIT];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  unlock_seq_a: assert property ((s.unlock == bscp_pkg::UL_HALF) && dwr && (s.ph_addr == bscp_pkg::UNLOCK_ADDR)
      && (hwdata[7:0] == bscp_pkg::UNLOCK_KEY2) && (s.rst_cnt == 8'h00) |=> s.unlock == bscp_pkg::UL_OPEN)
    else $error("unlock sequence did not open control writes");

  ctrl_locked_a: assert property (dwr && (s.ph_addr == bscp_pkg::BOOT_CTRL_ADDR) && (s.unlock != bscp_pkg::UL_OPEN)
      && (s.rst_cnt == 8'h00) |=> $stable(aux_ram_enable) && $stable(target_is_loader))
    else $error("control register changed while write-locked");

  reboot_hold_a: assert property (reboot_req |=> !sys_reset_n [*8])
    else $error("software reboot did not hold reset");

  reboot_clear_a: assert property (reboot_req |-> ##2 !isp_mode && !aux_ram_enable && !boot_from_loader)
    else $error("software reboot did not clear control state");

  flag_read_a: assert property (drd && (s.ph_addr == bscp_pkg::BOOT_CTRL_ADDR) |-> hrdata[7] == boot_from_loader)
    else $error("loader boot flag read back wrong");

  aux_write_a: assert property (ctrl_wr && !reboot_req |=> aux_ram_enable == $past(hwdata[4]))
    else $error("auxiliary RAM enable did not follow write");

  isp_entry_a: assert property (s.prog_en && core_idle && wake_irq && (s.rst_cnt == 8'h00) && !ctrl_wr
      |=> isp_mode ##0 (rom_op_allow == core_idle))
    else $error("reprogramming mode not entered on idle wake");

  rom_block_a: assert property (rom_op_allow |-> s.prog_en && isp_mode)
    else $error("memory operation allowed without enable");

  strap_boot_a: assert property ((s.cap_cnt == 2'h1) && (s.rst_cnt == 8'h00) && (s.s2 == 3'h7)
      |=> !boot_from_loader && sys_reset_n)
    else $error("default boot not from application bank");

  sec_sticky_a: assert property (((s.sec & ~$past(s.sec)) != 8'h00) |-> $past(dwr && (s.ph_addr == bscp_pkg::ERASE_ADDR)))
    else $error("security bit returned to one without erase");

  sec_hidden_a: assert property (isp_mode && drd && ((s.ph_addr == bscp_pkg::SECURITY_ADDR)
      || (s.ph_addr == bscp_pkg::ID_ADDR)) |-> hrdata == 32'h0000_0000)
    else $error("setting registers visible in programming mode");

  tbl_block_a: assert property (!tbl_from_internal && !s.sec[bscp_pkg::SEC_TBL_BIT] |-> !tbl_internal_grant)
    else $error("table read from external code reached internal memory");

  enc_data_a: assert property (!s.sec[bscp_pkg::SEC_ENC_BIT] |=> p0_data_out == ($past(p0_data_in) ^ ENC_KEY))
    else $error("port 0 data not encoded");

  gain_a: assert property ($fell(s.sec[7]) |-> osc_half_gain)
    else $error("oscillator gain not halved");

  // ----------------------------------------------------------------------
  // Bus and control checks
  // ----------------------------------------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave not ready or not okay");

  rd_idle_a: assert property (!drd |-> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read");

  status_read_a: assert property (drd && (s.ph_addr == bscp_pkg::STATUS_ADDR)
      |-> hrdata[7:0] == {3'h0, ~s.sec[bscp_pkg::SEC_ENC_BIT], target_is_loader, isp_mode, boot_from_loader,
      sys_reset_n})
    else $error("status register read back wrong");

  id_read_a: assert property (drd && (s.ph_addr == bscp_pkg::ID_ADDR) && !isp_mode && ext_access_allow
      |-> hrdata == {16'h0000, DEVICE_ID, COMPANY_ID})
    else $error("identity values read back wrong");

  sel_write_a: assert property (ctrl_wr && !reboot_req
      |=> target_is_loader == !$past(hwdata[bscp_pkg::CTRL_SEL_BIT]))
    else $error("loader location select did not follow write");

  en_write_a: assert property (ctrl_wr && !reboot_req
      |=> s.prog_en == $past(hwdata[bscp_pkg::CTRL_EN_BIT]))
    else $error("reprogramming enable did not follow write");

  unlock_half_a: assert property (dwr && (s.ph_addr == bscp_pkg::UNLOCK_ADDR)
      && (hwdata[7:0] == bscp_pkg::UNLOCK_KEY1) && (s.rst_cnt == 8'h00)
      |=> s.unlock == bscp_pkg::UL_HALF)
    else $error("first unlock key not taken");

  unlock_close_a: assert property (dwr && (s.ph_addr == bscp_pkg::UNLOCK_ADDR)
      && (hwdata[7:0] != bscp_pkg::UNLOCK_KEY1) && (hwdata[7:0] != bscp_pkg::UNLOCK_KEY2)
      |=> s.unlock == bscp_pkg::UL_CLOSED)
    else $error("other unlock value did not close control writes");

  reboot_lock_a: assert property ((s.rst_cnt != 8'h00) |=> s.unlock == bscp_pkg::UL_CLOSED)
    else $error("control writes open during reboot");

  reboot_ctrl_a: assert property ((s.rst_cnt != 8'h00)
      |=> !aux_ram_enable && target_is_loader && !s.prog_en)
    else $error("control bits not cleared during reboot");

  reboot_end_a: assert property ((s.rst_cnt == 8'h01)
      |=> !sys_reset_n && (s.cap_cnt == bscp_pkg::STRAP_SETTLE))
    else $error("reboot did not pass into strap settle");

  isp_exit_a: assert property (!s.prog_en && core_idle && wake_irq |=> !isp_mode)
    else $error("reprogramming mode entered without enable");

  rom_idle_a: assert property (rom_op_allow |-> core_idle)
    else $error("memory operation allowed outside idle");

  strap_loader_a: assert property ((s.cap_cnt == 2'h1) && (s.rst_cnt == 8'h00)
      && (!s.s2[2] || (s.s2[1:0] == 2'h0)) |=> boot_from_loader)
    else $error("strap pins did not force loader boot");

  // ----------------------------------------------------------------------
  // Security checks
  // ----------------------------------------------------------------------
  isp_freeze_a: assert property (isp_mode |=> $stable(s.sec))
    else $error("security byte changed in programming mode");

  lock_freeze_a: assert property (!s.sec[bscp_pkg::SEC_LOCK_BIT]
      && !(dwr && (s.ph_addr == bscp_pkg::ERASE_ADDR)) |=> $stable(s.sec))
    else $error("security byte changed while locked");

  sec_data_a: assert property (sec_hit && !isp_mode && ext_access_allow
      |=> sec_data == $past(s.sec))
    else $error("security byte not served at its address");

  sec_data_hide_a: assert property (!sec_hit || isp_mode || !ext_access_allow
      |=> sec_data == 8'h00)
    else $error("security byte served while hidden");

  enc_off_a: assert property (s.sec[bscp_pkg::SEC_ENC_BIT] |=> p0_data_out == $past(p0_data_in))
    else $error("port 0 data encoded while encryption is off");

  gain_follow_a: assert property (osc_half_gain == !s.sec[bscp_pkg::SEC_GAIN_BIT])
    else $error("oscillator gain does not follow security bit");

  tbl_free_a: assert property (tbl_to_internal && (tbl_from_internal || s.sec[bscp_pkg::SEC_TBL_BIT])
      |-> tbl_internal_grant)
    else $error("permitted table read refused");

  sec_erase_c: cover property ((s.sec != bscp_pkg::SEC_RESET) ##1 (s.sec == bscp_pkg::SEC_RESET));
  unlock_c: cover property (s.unlock == bscp_pkg::UL_HALF ##1 s.unlock == bscp_pkg::UL_OPEN);
  reboot_c: cover property (reboot_req ##1 !sys_reset_n);
  isp_c: cover property (!isp_mode ##1 isp_mode);
  loader_boot_c: cover property (!boot_from_loader ##1 boot_from_loader);

endmodule : bscp_top

//--- testbench/bscp_strap_model.sv
// Strap pin model for the boot-select block.
// Assumes the bench picks strap_mode before a reset; straps not pulled low sit high.
`timescale 1ns/1ps
module bscp_strap_model (
  input wire logic [1:0] strap_mode,
  output logic p2_6_pin,
  output logic p2_7_pin,
  output logic p4_3_pin
);
  // ----------
  // Straps
  // ----------
  // Mode 1 pulls both port 2 straps low, mode 2 pulls the port 4 strap low.
  assign p2_6_pin = (strap_mode != 2'h1);
  assign p2_7_pin = (strap_mode != 2'h1);
  assign p4_3_pin = (strap_mode != 2'h2);
endmodule : bscp_strap_model

//--- testbench/test_boot_select_code_protection.sv
// Self-checking bench for the boot-select and code-protection block.
// Assumes one AHB-Lite master here and the strap model on the pins.
`timescale 1ns/1ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module test_boot_select_code_protection;
  localparam logic [7:0] ENC = 8'h5a;
  localparam logic [7:0] CID = 8'h11; // Arbitrary value.
  localparam logic [7:0] DID = 8'h22; // Arbitrary value.
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic core_idle = 1'b0;
  logic wake_irq = 1'b0;
  logic tbl_from_internal = 1'b0;
  logic tbl_to_internal = 1'b0;
  logic loader_rd = 1'b0;
  logic [15:0] loader_addr = 16'h0;
  logic [7:0] p0_data_in = 8'h0;
  logic [1:0] strap_mode = 2'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, sys_reset_n, boot_from_loader, aux_ram_enable, target_is_loader, isp_mode;
  logic rom_op_allow, tbl_internal_grant, ext_access_allow, sec_hit, osc_half_gain;
  logic p2_6_pin, p2_7_pin, p4_3_pin;
  logic [7:0] sec_data, p0_data_out;
  int miscompares = 0;
  int cmp_count = 0;

  always #12.5 hclk = ~hclk;

  bscp_strap_model u_straps (.strap_mode, .p2_6_pin, .p2_7_pin, .p4_3_pin);
  bscp_top #(.ENC_KEY(ENC), .COMPANY_ID(CID), .DEVICE_ID(DID)) u_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata,
    .hreadyout, .hresp, .p2_6_pin, .p2_7_pin, .p4_3_pin, .core_idle, .wake_irq, .tbl_from_internal,
    .tbl_to_internal, .loader_rd, .loader_addr, .p0_data_in, .sys_reset_n, .boot_from_loader,
    .aux_ram_enable, .target_is_loader, .isp_mode, .rom_op_allow, .tbl_internal_grant,
    .ext_access_allow, .sec_hit, .sec_data, .p0_data_out, .osc_half_gain);

  // ----------
  // Tasks
  // ----------
  task automatic final_report();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // Waits for hready, takes read data, and returns at the sampling edge.
  task automatic wait_ready();
    int n;
    @(negedge hclk);
    for (n = 0; n < 20 && hreadyout !== 1'b1; n++) @(negedge hclk);
    if (n == 20) begin
      miscompares++;
      final_report();
    end
    rd = hrdata;
    @(posedge hclk);
  endtask : wait_ready

  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    wait_ready();
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(rd, e)
  endtask : rdchk

  task automatic unlock();
    wr(bscp_pkg::UNLOCK_ADDR, 8'h87);
    wr(bscp_pkg::UNLOCK_ADDR, 8'h59);
  endtask : unlock

  task automatic wait_sys();
    int n;
    for (n = 0; n < 60 && sys_reset_n !== 1'b1; n++) @(negedge hclk);
    if (n == 60) begin
      miscompares++;
      final_report();
    end
  endtask : wait_sys

  task automatic por(input logic [1:0] m);
    @(posedge hclk);
    strap_mode <= m;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wait_sys();
  endtask : por

  task automatic wake();
    @(posedge hclk);
    core_idle <= 1'b1;
    wake_irq <= 1'b1;
    @(posedge hclk);
    wake_irq <= 1'b0;
    repeat (2) @(negedge hclk);
  endtask : wake

  // ----------
  // Sequence
  // ----------
  initial begin
    por(2'h0);
    `CHK(boot_from_loader, 1'b0)
    rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h0);
    rdchk(bscp_pkg::STATUS_ADDR, 32'h09);
    `CHK({hreadyout, hresp}, 2'b10)
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h13);
    rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h0);
    unlock();
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h13);
    rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h13);
    `CHK({aux_ram_enable, target_is_loader}, 2'b10)
    wr(bscp_pkg::UNLOCK_ADDR, 8'h00);
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h01);
    rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h13);
    wake();
    `CHK({isp_mode, rom_op_allow}, 2'b11)
    rdchk(bscp_pkg::SECURITY_ADDR, 32'h0);
    rdchk(bscp_pkg::ID_ADDR, 32'h0);
    unlock();
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge hclk);
    `CHK({aux_ram_enable, target_is_loader, rom_op_allow}, 3'b010)
    wake();
    `CHK(isp_mode, 1'b0)
    rdchk(bscp_pkg::ID_ADDR, {16'h0, DID, CID});
    wr(bscp_pkg::SECURITY_ADDR, 8'h7b);
    p0_data_in <= 8'h3c;
    tbl_to_internal <= 1'b1;
    repeat (2) @(negedge hclk);
    `CHK({osc_half_gain, p0_data_out, tbl_internal_grant}, {1'b1, 8'h3c ^ ENC, 1'b1})
    wr(bscp_pkg::SECURITY_ADDR, 8'hff);
    rdchk(bscp_pkg::SECURITY_ADDR, 32'h7b);
    wr(bscp_pkg::SECURITY_ADDR, 8'h79);
    repeat (2) @(negedge hclk);
    `CHK(tbl_internal_grant, 1'b0)
    @(posedge hclk);
    tbl_from_internal <= 1'b1;
    loader_rd <= 1'b1;
    loader_addr <= 16'hffff;
    @(negedge hclk);
    `CHK({tbl_internal_grant, sec_hit}, 2'b11)
    @(negedge hclk);
    `CHK(sec_data, 8'h79)
    wr(bscp_pkg::SECURITY_ADDR, 8'h78);
    repeat (2) @(negedge hclk);
    `CHK(ext_access_allow, 1'b0)
    rdchk(bscp_pkg::ID_ADDR, 32'h0);
    wr(bscp_pkg::ERASE_ADDR, 8'ha5);
    rdchk(bscp_pkg::SECURITY_ADDR, 32'hff);
    unlock();
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h81);
    repeat (2) @(negedge hclk);
    `CHK(sys_reset_n, 1'b1)
    unlock();
    wr(bscp_pkg::BOOT_CTRL_ADDR, 8'h83);
    repeat (2) @(negedge hclk);
    `CHK(sys_reset_n, 1'b0)
    wait_sys();
    rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h0);
    for (int m = 1; m < 3; m++) begin
      por(m[1:0]);
      `CHK(boot_from_loader, 1'b1)
      rdchk(bscp_pkg::BOOT_CTRL_ADDR, 32'h80);
    end
    final_report();
  end
endmodule : test_boot_select_code_protection
